// ---- pm_regs_pkg.sv ----
// constants of the power management register block
// assumes byte addresses within the block's own i/o window
package pm_regs_pkg;
  // byte offsets inside the i/o window
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_ENABLE = 8'h02;
  localparam logic [7:0] OFF_SLEEP_CONTROL = 8'h04;
  localparam logic [7:0] OFF_TIMER = 8'h08;
  localparam logic [7:0] OFF_PROC_CONTROL = 8'h10;
  localparam logic [7:0] OFF_LEVEL2 = 8'h14;
  localparam logic [7:0] OFF_LEVEL3 = 8'h15;
  // status / enable bit positions (shared layout)
  localparam int BIT_TIMER_CARRY = 0;
  localparam int BIT_FW_ATTENTION = 5;
  localparam int BIT_BUTTON = 8;
  localparam int BIT_ALARM = 10;
  // sleep control fields
  localparam int BIT_ROUTE_SELECT = 0;
  localparam int BIT_BM_WAKE = 1;
  localparam int BIT_OWN_RELEASE = 2;
  localparam int POS_SUSPEND_TYPE = 10;
  localparam int BIT_SUSPEND_TRIGGER = 13;
  // processor control fields
  localparam int POS_THROTTLE_DUTY = 1;
  localparam int BIT_THROTTLE_EN = 4;
  localparam int BIT_CLOCK_CTRL_EN = 9;
  localparam int BIT_CLOCKRUN_EN = 13;
  localparam int BIT_THROTTLE_ACTIVE = 17;
  // reset values
  localparam logic [15:0] RST_ENABLE = 16'h0000;
  localparam logic [15:0] RST_SLEEP_CONTROL = 16'h1000;
  localparam logic [31:0] RST_PROC_CONTROL = 32'h0000_0000;
  // suspend type codes
  localparam logic [2:0] SUSP_WORKING = 3'h4;
  localparam logic [2:0] SUSP_SLEEPING = 3'h3;
  localparam logic [2:0] SUSP_DRAM = 3'h2;
  localparam logic [2:0] SUSP_DISK = 3'h1;
  localparam logic [2:0] SUSP_SOFT_OFF = 3'h0;
  // timing: system clock and timer reference
  localparam int CLK_HZ = 100_000_000;
  localparam int TIMER_REF_HZ = 3_579_545;
  localparam int TIMER_TICK_DIV = CLK_HZ / TIMER_REF_HZ;
  localparam int THROTTLE_SLOT_CYCLES = 64;
  localparam int CLOCKRUN_IDLE_CYCLES = 16;
  typedef enum logic [1:0] {cc_normal, cc_level2, cc_level3} clock_state_type;
endpackage : pm_regs_pkg

// ---- pm_timing_if.sv ----
// carrier between the register core, the timer and the throttle generator
// assumes all three sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface pm_timing_if;
  logic [31:0] timer_value;
  logic carry_pulse;
  logic throttle_en;
  logic [2:0] throttle_duty;
  logic throttle_stop;
  modport timer (output timer_value, output carry_pulse);
  modport throttle (input throttle_en, input throttle_duty, output throttle_stop);
  modport core (input timer_value, input carry_pulse, output throttle_en, output throttle_duty,
    input throttle_stop);
endinterface : pm_timing_if
`default_nettype wire

// ---- pm_timer.sv ----
// free-running power management timer
// assumes a clock of CLK_HZ; tick rate set by TICK_DIV
`timescale 1ns/1ps
`default_nettype none
module pm_timer import pm_regs_pkg::*; #(
  parameter int TICK_DIV = TIMER_TICK_DIV,
  parameter int WIDTH = 32
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  pm_timing_if.timer tif
);
  logic [7:0] div_q;
  logic [WIDTH-1:0] count_q;
  logic tick;
  assign tick = (div_q == 8'(TICK_DIV - 1));

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_q <= 8'h00;
      count_q <= '0;
    end else begin
      div_q <= tick ? 8'h00 : div_q + 8'h01;
      if (tick) count_q <= count_q + 1'b1;
    end
  end

  assign tif.timer_value = 32'(count_q);
  assign tif.carry_pulse = tick && (&count_q);
endmodule : pm_timer
`default_nettype wire

// ---- pm_throttle.sv ----
// cpu clock throttle duty generator: eight slots per period
// assumes duty code n means n slots running, the rest stopped
`timescale 1ns/1ps
`default_nettype none
module pm_throttle import pm_regs_pkg::*; #(
  parameter int SLOT_CYCLES = THROTTLE_SLOT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  pm_timing_if.throttle tif
);
  logic [7:0] slot_cnt_q;
  logic [2:0] slot_q;
  logic slot_end;
  assign slot_end = (slot_cnt_q == 8'(SLOT_CYCLES - 1));

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      slot_cnt_q <= 8'h00;
      slot_q <= 3'h0;
    end else if (!tif.throttle_en) begin
      slot_cnt_q <= 8'h00;
      slot_q <= 3'h0;
    end else begin
      slot_cnt_q <= slot_end ? 8'h00 : slot_cnt_q + 8'h01;
      if (slot_end) slot_q <= slot_q + 3'h1;
    end
  end

  assign tif.throttle_stop = tif.throttle_en && (slot_q >= tif.throttle_duty);
endmodule : pm_throttle
`default_nettype wire

// ---- pm_control_regs.sv ----
// power management i/o register block: event enables, sleep control,
// timer readout, processor clock control
// assumes the i/o window base is decoded outside (i_io_sel), dword lanes with byte enables
// Contract
// - alarm wake enable bit 10 passes alarm status to sci, smi or resume
// - button enable bit 8 passes button status to sci, smi or resume
// - firmware attention enable bit 5 raises sci only
// - timer carry enable bit 0 raises sci on carry status
// - reserved bits read as zero
// - suspend trigger bit 13 reads zero; writing one starts suspend sequence
// - suspend type field bits 12-10 with working, sleeping, dram, disk, off codes
// - writing one to ownership release bit 2 raises smi
// - bus-master wake bit 1 lets bus requests leave c3 to c0
// - route select bit 0 steers alarm and button events to sci or smi
// - timer bits 23-0 read running count
// - timer bits 31-24 read upper byte of 32-bit timer
// - throttle active flag bit 17 shows throttling mode
// - clockrun host enable bit 13 stops pci clock after idle period
// - clock control enable bit 9 lets level reads enter clock modes
// - throttle enable bit 4 switches cpu clock throttling
// - throttle duty bits 3-1 give n eighths high per period for n of 1 to 7; code 0 leaves the clock running
// - status bits clear on writing one, zero leaves them
// - timer carry status sets when timer msb falls
// - level 2 or level 3 register read requests that power state
`timescale 1ns/1ps
`default_nettype none
module pm_control_regs import pm_regs_pkg::*; #(
  parameter int TICK_DIV = TIMER_TICK_DIV,
  parameter int SLOT_CYCLES = THROTTLE_SLOT_CYCLES,
  parameter int IDLE_CYCLES = CLOCKRUN_IDLE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_io_sel,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_addr,
  input wire logic [3:0] i_io_be,
  input wire logic [31:0] i_io_wdata,
  output logic [31:0] o_io_rdata,
  input wire logic i_alarm_event,
  input wire logic i_power_button,
  input wire logic i_busmaster_request,
  input wire logic i_pci_busy,
  input wire logic i_firmware_attention,
  input wire logic i_clock_break,
  output logic o_sci,
  output logic o_smi,
  output logic o_resume_event,
  output logic o_suspend_request,
  output logic [2:0] o_suspend_type,
  output logic o_cpu_clock_stop,
  output logic o_pci_clock_stop,
  output logic [1:0] o_clock_state
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPINS = 4;
  logic [NPINS-1:0] pin_raw;
  logic [NPINS-1:0] pin_s1_q;
  logic [NPINS-1:0] pin_s2_q;
  logic [NPINS-1:0] pin_s3_q;
  logic [NPINS-1:0] pin_q;
  assign pin_raw = {i_pci_busy, i_busmaster_request, i_power_button, i_alarm_event};

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_sync
      // a change counts only once stages two and three agree
      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          pin_s1_q[gi] <= 1'b0;
          pin_s2_q[gi] <= 1'b0;
          pin_s3_q[gi] <= 1'b0;
          pin_q[gi] <= 1'b0;
        end else begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
          pin_s3_q[gi] <= pin_s2_q[gi];
          if (pin_s2_q[gi] == pin_s3_q[gi]) pin_q[gi] <= pin_s3_q[gi];
        end
      end
    end
  endgenerate

  wire alarm_lvl = pin_q[0];
  wire button_lvl = pin_q[1];
  wire bm_req_lvl = pin_q[2];
  wire pci_busy_lvl = pin_q[3];

  // ----------------------------------------------------------------
  // timer and throttle generator
  // ----------------------------------------------------------------
  pm_timing_if tif ();

  pm_timer #(.TICK_DIV(TICK_DIV), .WIDTH(32)) u_timer (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .tif(tif.timer)
  );

  pm_throttle #(.SLOT_CYCLES(SLOT_CYCLES)) u_throttle (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .tif(tif.throttle)
  );

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  wire [5:0] dw = i_io_addr[7:2];
  wire hit_status = i_io_sel && (dw == OFF_STATUS[7:2]);
  wire hit_control = i_io_sel && (dw == OFF_SLEEP_CONTROL[7:2]);
  wire hit_timer = i_io_sel && (dw == OFF_TIMER[7:2]);
  wire hit_proc = i_io_sel && (dw == OFF_PROC_CONTROL[7:2]);
  wire hit_level = i_io_sel && (dw == OFF_LEVEL2[7:2]);
  wire wr_status = hit_status && i_io_wr;
  wire wr_control = hit_control && i_io_wr;
  wire wr_proc = hit_proc && i_io_wr;
  wire [1:0] lane_level2_entry_read = OFF_LEVEL2[1:0];
  wire [1:0] lane_level3_entry_read = OFF_LEVEL3[1:0];
  wire level2_entry_read = hit_level && i_io_rd && i_io_be[lane_level2_entry_read];
  wire level3_entry_read = hit_level && i_io_rd && i_io_be[lane_level3_entry_read];

  // byte-lane merge of the write data over a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = wd[8*b +: 8];
    end
    return r;
  endfunction

  // write-one-to-clear mask for the status half (bytes 0 and 1)
  wire [15:0] status_clear = i_io_wdata[15:0] & {{8{i_io_be[1]}}, {8{i_io_be[0]}}} & {16{wr_status}};

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [15:0] enable_q;
  logic [15:0] control_q;
  logic [31:0] proc_q;
  logic alarm_sts_q;
  logic button_sts_q;
  logic fw_sts_q;
  logic carry_sts_q;
  logic suspend_req_q;
  logic release_q;

  wire [31:0] enable_wr = merge({enable_q, 16'h0000}, i_io_wdata, i_io_be);
  wire [31:0] control_wr = merge({16'h0000, control_q}, i_io_wdata, i_io_be);
  wire [31:0] proc_wr = merge(proc_q, i_io_wdata, i_io_be);
  wire [15:0] enable_mask = 16'h0521;
  wire [15:0] control_mask = 16'h1c07;
  wire [31:0] proc_mask = 32'h0000_221e;
  wire trigger_written = wr_control && i_io_be[1] && i_io_wdata[BIT_SUSPEND_TRIGGER];
  wire release_written = wr_control && i_io_be[0] && i_io_wdata[BIT_OWN_RELEASE];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      enable_q <= RST_ENABLE;
      control_q <= RST_SLEEP_CONTROL;
      proc_q <= RST_PROC_CONTROL;
    end else begin
      if (wr_status) enable_q <= enable_wr[31:16] & enable_mask;
      if (wr_control) control_q <= control_wr[15:0] & control_mask;
      if (wr_proc) proc_q <= proc_wr & proc_mask;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      alarm_sts_q <= 1'b0;
      button_sts_q <= 1'b0;
      fw_sts_q <= 1'b0;
      carry_sts_q <= 1'b0;
    end else begin
      alarm_sts_q <= alarm_lvl | (alarm_sts_q & ~status_clear[BIT_ALARM]);
      button_sts_q <= button_lvl | (button_sts_q & ~status_clear[BIT_BUTTON]);
      fw_sts_q <= i_firmware_attention | (fw_sts_q & ~status_clear[BIT_FW_ATTENTION]);
      carry_sts_q <= tif.carry_pulse | (carry_sts_q & ~status_clear[BIT_TIMER_CARRY]);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      suspend_req_q <= 1'b0;
      release_q <= 1'b0;
    end else begin
      suspend_req_q <= trigger_written;
      release_q <= release_written;
    end
  end

  // ----------------------------------------------------------------
  // field views
  // ----------------------------------------------------------------
  wire alarm_wake_enable = enable_q[BIT_ALARM];
  wire button_event_enable = enable_q[BIT_BUTTON];
  wire firmware_attention_enable = enable_q[BIT_FW_ATTENTION];
  wire timer_carry_event_enable = enable_q[BIT_TIMER_CARRY];
  wire interrupt_route_select = control_q[BIT_ROUTE_SELECT];
  wire busmaster_wake_enable = control_q[BIT_BM_WAKE];
  wire [2:0] suspend_type = control_q[POS_SUSPEND_TYPE +: 3];
  wire throttle_enable = proc_q[BIT_THROTTLE_EN];
  wire [2:0] throttle_duty = proc_q[POS_THROTTLE_DUTY +: 3];
  wire clock_ctrl_enable = proc_q[BIT_CLOCK_CTRL_EN];
  wire clockrun_host_enable = proc_q[BIT_CLOCKRUN_EN];

  // ----------------------------------------------------------------
  // power events
  // ----------------------------------------------------------------
  // enable gating of alarm, button, firmware attention and timer carry status
  wire alarm_ev = alarm_wake_enable & alarm_sts_q;
  wire button_ev = button_event_enable & button_sts_q;
  wire fw_ev = firmware_attention_enable & fw_sts_q;
  wire carry_ev = timer_carry_event_enable & carry_sts_q;
  wire wake_ev = alarm_ev | button_ev;
  wire sci_d = (interrupt_route_select & wake_ev) | fw_ev | carry_ev;
  wire smi_d = (~interrupt_route_select & wake_ev) | release_q;

  // ----------------------------------------------------------------
  // processor clock control states
  // ----------------------------------------------------------------
  // software is expected to program the working type before level entry; not enforced here
  clock_state_type cc_q;
  clock_state_type cc_d;

  always_comb begin
    cc_d = cc_q;
    unique case (cc_q)
      cc_normal: begin
        if (clock_ctrl_enable && level3_entry_read) cc_d = cc_level3;
        else if (clock_ctrl_enable && level2_entry_read) cc_d = cc_level2;
      end
      cc_level2: begin
        if (i_clock_break || !clock_ctrl_enable) cc_d = cc_normal;
      end
      cc_level3: begin
        if (i_clock_break || !clock_ctrl_enable || (busmaster_wake_enable && bm_req_lvl)) cc_d = cc_normal;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) cc_q <= cc_normal;
    else cc_q <= cc_d;
  end

  assign tif.throttle_en = throttle_enable && (throttle_duty != 3'h0) && (cc_q == cc_normal);
  assign tif.throttle_duty = throttle_duty;
  wire throttle_active_flag = tif.throttle_en;

  // ----------------------------------------------------------------
  // pci clock run host
  // ----------------------------------------------------------------
  // the idle count restarts while the synchronised busy level is high; a request raised after the stop clears it once the synchronised busy level rises
  logic [15:0] idle_cnt_q;
  logic pci_stop_q;
  wire idle_done = (idle_cnt_q == 16'(IDLE_CYCLES - 1));

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      idle_cnt_q <= 16'h0000;
      pci_stop_q <= 1'b0;
    end else if (!clockrun_host_enable || pci_busy_lvl) begin
      idle_cnt_q <= 16'h0000;
      pci_stop_q <= 1'b0;
    end else if (!idle_done) begin
      idle_cnt_q <= idle_cnt_q + 16'h0001;
    end else begin
      pci_stop_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic sci_q;
  logic smi_q;
  logic resume_q;
  logic cpu_stop_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sci_q <= 1'b0;
      smi_q <= 1'b0;
      resume_q <= 1'b0;
      cpu_stop_q <= 1'b0;
    end else begin
      sci_q <= sci_d;
      smi_q <= smi_d;
      resume_q <= wake_ev;
      cpu_stop_q <= (cc_q != cc_normal) | tif.throttle_stop;
    end
  end

  assign o_sci = sci_q;
  assign o_smi = smi_q;
  assign o_resume_event = resume_q;
  assign o_suspend_request = suspend_req_q;
  assign o_suspend_type = suspend_type;
  assign o_cpu_clock_stop = cpu_stop_q;
  assign o_pci_clock_stop = pci_stop_q;
  assign o_clock_state = cc_q;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire [15:0] status_view = 16'(alarm_sts_q) << BIT_ALARM | 16'(button_sts_q) << BIT_BUTTON
    | 16'(fw_sts_q) << BIT_FW_ATTENTION | 16'(carry_sts_q) << BIT_TIMER_CARRY;
  wire [15:0] control_view = control_q & ~(16'h0001 << BIT_SUSPEND_TRIGGER);
  wire [31:0] proc_view = proc_q | (32'(throttle_active_flag) << BIT_THROTTLE_ACTIVE);
  wire [31:0] timer_view = tif.timer_value;

  wire [31:0] rd_mux = hit_status ? {enable_q, status_view}
    : hit_control ? {16'h0000, control_view}
    : hit_timer ? timer_view
    : hit_proc ? proc_view
    : 32'h0000_0000;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) o_io_rdata <= 32'h0000_0000;
    else if (i_io_sel && i_io_rd) o_io_rdata <= rd_mux;
  end
endmodule : pm_control_regs
`default_nettype wire

// ---- pm_control_regs_chk.sv ----
// checker for the power management register block
// assumes binding to pm_control_regs, one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module pm_control_regs_chk import pm_regs_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_io_sel,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_addr,
  input wire logic [3:0] i_io_be,
  input wire logic [31:0] i_io_wdata,
  input wire logic [31:0] o_io_rdata,
  input wire logic i_clock_break,
  input wire logic o_sci,
  input wire logic o_smi,
  input wire logic o_suspend_request,
  input wire logic [2:0] o_suspend_type,
  input wire logic [1:0] o_clock_state
);
  // ----------------------------------------
  // access decode
  // ----------------------------------------
  wire logic rd_any = i_io_sel && i_io_rd;
  wire logic ctl_wr = i_io_sel && i_io_wr && i_io_addr[7:2] == 6'h01;
  wire logic type_wr = ctl_wr && i_io_be[1];
  wire logic trig_wr = type_wr && i_io_wdata[13];
  wire logic rel_wr = ctl_wr && i_io_be[0] && i_io_wdata[2];
  wire logic [2:0] wtype = i_io_wdata[12:10];
  wire logic lvl_rd = rd_any && i_io_addr[7:2] == 6'h05 && (i_io_be[0] || i_io_be[1]);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_trigger_one_cycle: assert property (o_suspend_request |=> !o_suspend_request)
    else $error("suspend request wider than one cycle");
  a_trigger_cause: assert property (o_suspend_request |-> $past(trig_wr))
    else $error("suspend request without trigger write");
  a_type_hold: assert property (!type_wr |=> $stable(o_suspend_type))
    else $error("suspend type changed without write");
  a_type_load: assert property (type_wr |=> o_suspend_type == $past(wtype))
    else $error("suspend type not loaded");
  a_release_smi: assert property (rel_wr |-> ##[1:3] o_smi)
    else $error("no smi after ownership release");
  a_rdata_hold: assert property (!rd_any |=> $stable(o_io_rdata))
    else $error("read data moved without read");
  a_enable_reserved: assert property (rd_any && i_io_addr[7:2] == 6'h00 |=>
    (o_io_rdata & ~32'h0521_0521) == 32'h0)
    else $error("reserved status or enable bit set");
  a_ctrl_reserved: assert property (rd_any && i_io_addr[7:2] == 6'h01 |=>
    (o_io_rdata & ~32'h0000_1c07) == 32'h0)
    else $error("reserved or trigger control bit set");
  a_proc_reserved: assert property (rd_any && i_io_addr[7:2] == 6'h04 |=>
    (o_io_rdata & ~32'h0002_221e) == 32'h0)
    else $error("reserved processor control bit set");
  a_level_entry: assert property (o_clock_state != $past(o_clock_state) && o_clock_state != cc_normal
    |-> $past(lvl_rd))
    else $error("level state entered without level read");
  a_break_exit: assert property (o_clock_state != cc_normal && i_clock_break && !lvl_rd
    |=> o_clock_state == cc_normal)
    else $error("clock break did not leave level state");
  c_suspend: cover property (o_suspend_request);
  c_smi: cover property (o_smi);
  c_sci: cover property (o_sci);
  c_level3: cover property (o_clock_state == cc_level3);
endmodule : pm_control_regs_chk
bind pm_control_regs pm_control_regs_chk u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_io_sel(i_io_sel),
  .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_addr(i_io_addr), .i_io_be(i_io_be), .i_io_wdata(i_io_wdata),
  .o_io_rdata(o_io_rdata), .i_clock_break(i_clock_break), .o_sci(o_sci), .o_smi(o_smi),
  .o_suspend_request(o_suspend_request), .o_suspend_type(o_suspend_type), .o_clock_state(o_clock_state));
`default_nettype wire

// ---- pm_control_regs_tb.sv ----
// self-checking bench for the power management register block
// assumes short timer tick, throttle slot and idle parameters
`timescale 1ns/1ps
`default_nettype none
module pm_control_regs_tb import pm_regs_pkg::*; ;
  logic i_clk, i_rst_b, i_io_sel, i_io_wr, i_io_rd;
  logic [7:0] i_io_addr;
  logic [3:0] i_io_be;
  logic [31:0] i_io_wdata, o_io_rdata;
  logic i_alarm_event, i_power_button, i_busmaster_request, i_pci_busy, i_firmware_attention, i_clock_break;
  logic o_sci, o_smi, o_resume_event, o_suspend_request, o_cpu_clock_stop, o_pci_clock_stop;
  logic [2:0] o_suspend_type;
  logic [1:0] o_clock_state;
  int n_mismatch, tests_run, cyc;
  pm_control_regs #(.TICK_DIV(2), .SLOT_CYCLES(2), .IDLE_CYCLES(4)) u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_io_sel(i_io_sel), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_addr(i_io_addr), .i_io_be(i_io_be),
    .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata), .i_alarm_event(i_alarm_event),
    .i_power_button(i_power_button), .i_busmaster_request(i_busmaster_request), .i_pci_busy(i_pci_busy),
    .i_firmware_attention(i_firmware_attention), .i_clock_break(i_clock_break), .o_sci(o_sci), .o_smi(o_smi),
    .o_resume_event(o_resume_event), .o_suspend_request(o_suspend_request), .o_suspend_type(o_suspend_type),
    .o_cpu_clock_stop(o_cpu_clock_stop), .o_pci_clock_stop(o_pci_clock_stop), .o_clock_state(o_clock_state));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task cycles(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cycles
  task io_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge i_clk);
    i_io_sel = 1'b1;
    i_io_wr = 1'b1;
    i_io_addr = a;
    i_io_be = b;
    i_io_wdata = d;
    @(negedge i_clk);
    i_io_sel = 1'b0;
    i_io_wr = 1'b0;
  endtask : io_wr
  task io_rd(input logic [7:0] a, input logic [3:0] b, output logic [31:0] d);
    @(negedge i_clk);
    i_io_sel = 1'b1;
    i_io_rd = 1'b1;
    i_io_addr = a;
    i_io_be = b;
    @(negedge i_clk);
    i_io_sel = 1'b0;
    i_io_rd = 1'b0;
    @(negedge i_clk);
    d = o_io_rdata;
  endtask : io_rd
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    logic [31:0] d;
    io_rd(OFF_SLEEP_CONTROL, 4'hf, d);
    check(d, {16'h0, RST_SLEEP_CONTROL});
    check({29'h0, o_suspend_type}, {29'h0, SUSP_WORKING});
    io_rd(OFF_PROC_CONTROL, 4'hf, d);
    check(d, RST_PROC_CONTROL);
    io_wr(8'h00, 4'hc, 32'hffff_0000);
    io_rd(8'h00, 4'hf, d);
    check(d, 32'h0521_0000);
    io_rd(8'h0c, 4'hf, d);
    check(d, 32'h0);
  endtask : t_reset
  task t_events;
    logic [31:0] d;
    io_wr(8'h00, 4'hc, 32'h0500_0000);
    io_wr(OFF_SLEEP_CONTROL, 4'h3, 32'h0000_1001);
    i_firmware_attention = 1'b1;
    cycles(1);
    i_firmware_attention = 1'b0;
    cycles(3);
    check({30'h0, o_sci, o_smi}, 32'h0);
    i_alarm_event = 1'b1;
    cycles(8);
    i_alarm_event = 1'b0;
    check({29'h0, o_sci, o_smi, o_resume_event}, 32'h5);
    io_rd(8'h00, 4'hf, d);
    check(d, 32'h0500_0420);
    io_wr(8'h00, 4'h3, 32'h0000_0400);
    cycles(2);
    check({29'h0, o_sci, o_smi, o_resume_event}, 32'h0);
    io_wr(OFF_SLEEP_CONTROL, 4'h3, 32'h0000_1000);
    i_power_button = 1'b1;
    cycles(8);
    i_power_button = 1'b0;
    check({29'h0, o_sci, o_smi, o_resume_event}, 32'h3);
    // the synchronised button level must fall first, or the set beats the clear
    cycles(4);
    io_wr(8'h00, 4'h3, 32'h0000_0100);
    io_wr(8'h00, 4'hc, 32'h0520_0000);
    cycles(2);
    check({30'h0, o_sci, o_smi}, 32'h2);
    io_wr(8'h00, 4'h1, 32'h0000_0020);
    cycles(2);
    check({30'h0, o_sci, o_smi}, 32'h0);
  endtask : t_events
  task t_suspend;
    logic [31:0] d;
    logic seen;
    for (int c = 0; c < 5; c++) begin
      io_wr(OFF_SLEEP_CONTROL, 4'h2, 32'h2000 | (32'(c) << 10));
      check({31'h0, o_suspend_request}, 32'h1);
      io_rd(OFF_SLEEP_CONTROL, 4'hf, d);
      check(d, 32'(c) << 10);
      check({29'h0, o_suspend_type}, 32'(c));
    end
    io_wr(OFF_SLEEP_CONTROL, 4'h3, 32'h0000_1004);
    seen = 1'b0;
    repeat (4) @(negedge i_clk) seen = seen | o_smi;
    check({31'h0, seen}, 32'h1);
  endtask : t_suspend
  task t_timer;
    logic [31:0] a, b;
    io_rd(OFF_TIMER, 4'hf, a);
    cycles(17);
    io_rd(OFF_TIMER, 4'hf, b);
    // reads taken 20 cycles apart, one tick per 2 cycles
    check(b - a, 32'd10);
  endtask : t_timer
  task t_clock;
    logic [31:0] d;
    int run;
    io_wr(OFF_SLEEP_CONTROL, 4'h3, 32'h0000_1002);
    io_rd(OFF_LEVEL2, 4'h1, d);
    check({30'h0, o_clock_state}, {30'h0, cc_normal});
    io_wr(OFF_PROC_CONTROL, 4'h2, 32'h0000_0200);
    io_rd(OFF_LEVEL2, 4'h1, d);
    check({29'h0, o_cpu_clock_stop, o_clock_state}, {29'h0, 1'b1, cc_level2});
    i_clock_break = 1'b1;
    cycles(1);
    i_clock_break = 1'b0;
    cycles(1);
    check({30'h0, o_clock_state}, {30'h0, cc_normal});
    for (int w = 1; w >= 0; w--) begin
      io_wr(OFF_SLEEP_CONTROL, 4'h3, {30'h0, w[0], 1'b0} | 32'h1000);
      io_rd(OFF_LEVEL2, 4'h2, d);
      check({30'h0, o_clock_state}, {30'h0, cc_level3});
      i_busmaster_request = 1'b1;
      cycles(6);
      i_busmaster_request = 1'b0;
      check({30'h0, o_clock_state}, w ? {30'h0, cc_normal} : {30'h0, cc_level3});
    end
    i_clock_break = 1'b1;
    cycles(2);
    i_clock_break = 1'b0;
    // throttle period is 16 cycles, so 64 cycles hold four whole periods
    for (int n = 1; n < 8; n += 5) begin
      io_wr(OFF_PROC_CONTROL, 4'h1, 32'h10 | (32'(n) << 1));
      cycles(20);
      run = 0;
      repeat (64) @(negedge i_clk) run += int'(!o_cpu_clock_stop);
      check(32'(run), 32'(n * 8));
      io_rd(OFF_PROC_CONTROL, 4'hf, d);
      check(d, 32'h0002_0210 | (32'(n) << 1));
    end
    io_wr(OFF_PROC_CONTROL, 4'h1, 32'h0);
    io_rd(OFF_PROC_CONTROL, 4'hf, d);
    check(d, 32'h0000_0200);
    io_wr(OFF_PROC_CONTROL, 4'h2, 32'h0000_2000);
    cycles(12);
    check({31'h0, o_pci_clock_stop}, 32'h1);
    i_pci_busy = 1'b1;
    cycles(6);
    check({31'h0, o_pci_clock_stop}, 32'h0);
  endtask : t_clock
  // ----------------------------------------
  // main sequence and hang guard
  // ----------------------------------------
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    {i_io_sel, i_io_wr, i_io_rd, i_io_addr, i_io_be, i_io_wdata} = '0;
    {i_alarm_event, i_power_button, i_busmaster_request, i_firmware_attention, i_clock_break} = '0;
    i_pci_busy = 1'b0;
    i_rst_b = 1'b0;
    cycles(20);
    i_rst_b = 1'b1;
    t_reset();
    t_events();
    t_suspend();
    t_timer();
    t_clock();
    give_verdict();
  end
endmodule : pm_control_regs_tb
`default_nettype wire
